//--- hw/ccs_steer.v
/*
 * Cascade steering for one chained search device: APB register file,
 * host access selection (targeted or broadcast), search sequence
 * timing, hit/empty priority chain and shared bus drive enables.
 * Assumes neighbour devices run on the same sys_clk; chain inputs
 * arriving from another device pass a three-stage synchroniser.
 */
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "ccs_regs.vh"
module ccs_steer (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire        host_drive_en,
    input  wire [31:0] key_input_bus,
    input  wire        key_write_pulse,
    input  wire        local_hit,
    input  wire        local_multi_hit,
    input  wire        local_empty,
    input  wire [31:0] local_hit_addr,
    input  wire [31:0] local_hit_entry,
    input  wire [31:0] local_empty_entry,
    input  wire        hit_chain_in_n,
    input  wire        multi_hit_chain_in_n,
    input  wire        empty_chain_in_n,
    output wire        hit_chain_out_n,
    output wire        multi_hit_chain_out_n,
    output wire        empty_chain_out_n,
    input  wire        op_start,
    output reg  [31:0] result_output_bus,
    output wire        result_drive_en,
    output wire        ip_busy_n,
    output wire        op_busy_n,
    output wire        seq_hit_n,
    output wire        table_write_pulse
);

    // Chain synchronisers; first stage feeds only the second
    // Reset to the idle high level so no false change follows reset
    reg  [2:0] hit_sync_ff;
    reg  [2:0] mh_sync_ff;
    reg  [2:0] em_sync_ff;
    reg        hit_up_ff;
    reg        mh_up_ff;
    reg        em_up_ff;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hit_sync_ff <= 3'h7;
            mh_sync_ff  <= 3'h7;
            em_sync_ff  <= 3'h7;
            hit_up_ff   <= 1'b0;
            mh_up_ff    <= 1'b0;
            em_up_ff    <= 1'b0;
        end else begin
            hit_sync_ff <= {hit_sync_ff[1:0], hit_chain_in_n};
            mh_sync_ff  <= {mh_sync_ff[1:0], multi_hit_chain_in_n};
            em_sync_ff  <= {em_sync_ff[1:0], empty_chain_in_n};
            // Change accepted once stages two and three agree
            if (hit_sync_ff[1] == hit_sync_ff[2])
                hit_up_ff <= ~hit_sync_ff[2];
            if (mh_sync_ff[1] == mh_sync_ff[2])
                mh_up_ff <= ~mh_sync_ff[2];
            if (em_sync_ff[1] == em_sync_ff[2])
                em_up_ff <= ~em_sync_ff[2];
        end
    end

    // Registers
    // Five-bit device number: at most 32 devices in one chain
    reg        all_devices_flag_ff;
    reg  [4:0] target_device_number_ff;
    reg  [4:0] own_number_ff;
    reg        bottom_of_chain_flag_ff;
    reg [31:0] ip_cfg_ff;
    reg [31:0] op_cfg_ff;
    reg [31:0] compare_data_register_ff;
    reg [31:0] highest_hit_address_ff;
    reg [31:0] hit_entry_data_ff;
    reg  [1:0] hit_summary_status_ff;
    reg [31:0] sequence_hit_flags_ff;
    reg  [1:0] ctrl_ff;
    reg  [3:0] ip_cnt_ff;
    reg  [3:0] op_cnt_ff;
    reg  [1:0] op_step_ff;
    reg        op_done_ff;
    reg  [4:0] seq_idx_ff;

    // Priority: uppermost hit/free entry wins, passed downward
    wire hit_prio   = local_hit & ~hit_up_ff;
    wire empty_prio = local_empty & ~em_up_ff;
    assign hit_chain_out_n   = ~(local_hit | hit_up_ff);
    // Multi-hit: own multi, upper multi, or own hit under an upper hit
    assign multi_hit_chain_out_n = ~(local_multi_hit | mh_up_ff | (local_hit & hit_up_ff));
    assign empty_chain_out_n = ~(local_empty | em_up_ff);
    // System view; only meaningful in the bottom device
    wire sys_hit = ~hit_chain_out_n;
    wire sys_multi = ~multi_hit_chain_out_n;

    // Access steering
    localparam ATT_ALL = 2'd0;
    localparam ATT_HIT = 2'd1;
    localparam ATT_EMP = 2'd2;
    localparam ATT_BOT = 2'd3;

    // Which device answers or takes a broadcast access to an offset
    function [1:0] ccs_attr;
        input [11:0] a;
        begin
            case (a)
                `CCS_OFS_HHA, `CCS_OFS_HIT_DATA: ccs_attr = ATT_HIT;
                `CCS_OFS_TABLE:                  ccs_attr = ATT_EMP;
                default:                         ccs_attr = ATT_BOT;
            endcase
        end
    endfunction

    // Registers that must hold the same data in every device
    function ccs_common;
        input [11:0] a;
        begin
            ccs_common = (a == `CCS_OFS_SELECT) || (a == `CCS_OFS_IP_CFG) ||
                         (a == `CCS_OFS_OP_CFG) || (a == `CCS_OFS_CTRL);
        end
    endfunction

    wire [1:0] attr = ccs_attr(paddr);
    wire targeted_me = ~all_devices_flag_ff & (target_device_number_ff == own_number_ff);
    // Priority lags the chain by the synchroniser; host waits after a search
    // No free entry anywhere: the bottom device answers instead
    wire prio_me = (attr == ATT_HIT) ? (hit_prio | (~sys_hit & bottom_of_chain_flag_ff)) :
                   (attr == ATT_EMP) ? (empty_prio | (~em_up_ff & ~local_empty & bottom_of_chain_flag_ff)) :
                   bottom_of_chain_flag_ff;
    // Common registers ignore the target number on writes
    wire wr_me = ccs_common(paddr) ? 1'b1 :
                 (all_devices_flag_ff ? ((attr == ATT_BOT) ? 1'b1 : prio_me) : targeted_me);
    wire rd_me = all_devices_flag_ff ? prio_me : targeted_me;
    wire acc = psel & penable;
    wire wr_en = acc & pwrite & wr_me;
    // Zero wait states: every access completes in its first access cycle
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    // Only the selected device answers a read
    assign host_drive_en = acc & ~pwrite & rd_me;
    // Layout writes broadcast; otherwise the port is targeted
    assign table_write_pulse = acc & pwrite & (paddr == `CCS_OFS_TABLE) &
                               (ctrl_ff[`CCS_CTRL_TC_BIT] ? 1'b1 : targeted_me);

    // Register writes and search result capture
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            {all_devices_flag_ff, target_device_number_ff} <= `CCS_RST_SELECT;
            own_number_ff            <= 5'h00;
            bottom_of_chain_flag_ff  <= 1'b0;
            ip_cfg_ff                <= `CCS_RST_ZERO;
            op_cfg_ff                <= `CCS_RST_ZERO;
            compare_data_register_ff <= `CCS_RST_ZERO;
            highest_hit_address_ff   <= `CCS_RST_ZERO;
            hit_entry_data_ff        <= `CCS_RST_ZERO;
            hit_summary_status_ff    <= 2'h0;
            sequence_hit_flags_ff    <= `CCS_RST_ZERO;
            ctrl_ff                  <= 2'h0;
        end else begin
            // Read-only and unmapped offsets ignore writes, no error
            if (wr_en) begin
                case (paddr)
                    `CCS_OFS_SELECT: begin
                        all_devices_flag_ff     <= pwdata[`CCS_SEL_ALL_BIT];
                        target_device_number_ff <= pwdata[`CCS_SEL_NUM_MSB:0];
                    end
                    `CCS_OFS_IDENT: begin
                        own_number_ff           <= pwdata[4:0];
                        bottom_of_chain_flag_ff <= pwdata[`CCS_IDENT_BOT_BIT];
                    end
                    `CCS_OFS_IP_CFG: ip_cfg_ff <= pwdata;
                    `CCS_OFS_OP_CFG: op_cfg_ff <= pwdata;
                    `CCS_OFS_CTRL:   ctrl_ff   <= pwdata[1:0];
                    default: ;
                endcase
            end
            // Search results: three regs, plus two on key-port search
            if (key_write_pulse) begin
                compare_data_register_ff <= key_input_bus & ~ip_cfg_ff;
                sequence_hit_flags_ff[seq_idx_ff] <= local_hit;
            end
            if (ip_cnt_ff == 4'h1) begin
                highest_hit_address_ff <= local_hit_addr;
                hit_entry_data_ff      <= local_hit_entry;
                hit_summary_status_ff  <= {local_multi_hit, local_hit};
            end
        end
    end

    // Input sequence: identical fixed length in every device
    reg [4:0] nxt_seq_idx;
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ip_cnt_ff  <= 4'h0;
            seq_idx_ff <= 5'h00;
        end else begin
            // A new pulse restarts the count; searches must not overlap
            if (key_write_pulse)
                ip_cnt_ff <= `CCS_IP_BUSY_CYC;
            else if (ip_cnt_ff != 4'h0)
                ip_cnt_ff <= ip_cnt_ff - 4'h1;
            seq_idx_ff <= nxt_seq_idx;
        end
    end
    always @* begin
        nxt_seq_idx = seq_idx_ff;
        if (key_write_pulse)
            nxt_seq_idx = seq_idx_ff + 5'h01;
    end
    assign ip_busy_n = (ip_cnt_ff == 4'h0);
    // Own table only; the pins are wired together outside the device
    assign seq_hit_n = ~local_hit;

    // Output sequence states
    // A start outside the idle state is ignored
    localparam OP_IDLE = 3'b001;
    localparam OP_RUN  = 3'b010;
    localparam OP_END  = 3'b100;
    reg [2:0] op_st_ff;
    reg [2:0] nxt_op_st;
    always @* begin
        case (op_st_ff)
            OP_IDLE: nxt_op_st = op_start ? OP_RUN : OP_IDLE;
            OP_RUN:  nxt_op_st = (op_cnt_ff == 4'h1) ? OP_END : OP_RUN;
            OP_END:  nxt_op_st = OP_IDLE;
            default: nxt_op_st = OP_IDLE;
        endcase
    end
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            op_st_ff  <= OP_IDLE;
            op_cnt_ff <= 4'h0;
        end else begin
            op_st_ff <= nxt_op_st;
            if (op_st_ff == OP_IDLE && op_start)
                op_cnt_ff <= `CCS_OP_STEP_CYC;
            else if (op_cnt_ff != 4'h0)
                op_cnt_ff <= op_cnt_ff - 4'h1;
        end
    end
    // Busy only ends meaningfully in the bottom device
    assign op_busy_n = (op_st_ff == OP_IDLE);

    // Output bus source select: 0 compare,1 summary,2 address,3 entry
    // Summary comes from the bottom unless auto address is set; the bottom holds the system view
    wire [1:0] op_sel = op_cfg_ff[1:0];
    wire from_bottom_only = (op_sel == 2'd1);
    wire auto_addr = ctrl_ff[`CCS_CTRL_AUTO_BIT];
    // Auto address output drives on any own hit; may collide
    wire op_me = auto_addr ? local_hit :
                 from_bottom_only ? bottom_of_chain_flag_ff :
                 (hit_prio | (~sys_hit & bottom_of_chain_flag_ff));
    assign result_drive_en = (op_st_ff == OP_RUN) & op_me;
    wire [31:0] addr_word = {hit_prio, highest_hit_address_ff[30:0]};

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn)
            result_output_bus <= `CCS_RST_ZERO;
        else begin
            case (op_sel)
                2'd0: result_output_bus <= compare_data_register_ff;
                2'd1: result_output_bus <= {30'h0, sys_multi, sys_hit};
                2'd2: result_output_bus <= addr_word;
                default: result_output_bus <= hit_entry_data_ff;
            endcase
        end
    end

    // Read data: broadcast returns system view, targeted own view
    // Unmapped offsets read as zero; no slave error is raised
    always @* begin
        case (paddr)
            `CCS_OFS_SELECT:   prdata = {26'h0, all_devices_flag_ff, target_device_number_ff};
            `CCS_OFS_IDENT:    prdata = {26'h0, bottom_of_chain_flag_ff, own_number_ff};
            `CCS_OFS_IP_CFG:   prdata = ip_cfg_ff;
            `CCS_OFS_OP_CFG:   prdata = op_cfg_ff;
            `CCS_OFS_HHA:      prdata = {local_hit, highest_hit_address_ff[30:0]};
            `CCS_OFS_HIT_DATA: prdata = hit_entry_data_ff;
            `CCS_OFS_HIT_SUMMARY_STATUS:    prdata = all_devices_flag_ff ? {30'h0, sys_multi, sys_hit} :
                                        {30'h0, hit_summary_status_ff};
            `CCS_OFS_CMP:      prdata = compare_data_register_ff;
            `CCS_OFS_SEQ_HIT:  prdata = sequence_hit_flags_ff;
            `CCS_OFS_TABLE:    prdata = local_empty_entry;
            `CCS_OFS_CTRL:     prdata = {30'h0, ctrl_ff};
            `CCS_OFS_STATUS:   prdata = {27'h0, hit_prio, empty_prio, ~ip_busy_n, ~op_busy_n, local_hit};
            default:           prdata = `CCS_RST_ZERO;
        endcase
    end

endmodule

//--- hw/ccs_regs.vh
/*
 * Constants for the cascade steering block: APB register offsets,
 * field positions, reset values, sequence cycle counts and device limit.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
// Notes on behaviour
// - Broadcast writes load same sequence configuration everywhere
// - Broadcast config reads answered by bottom device
// - Shared key bus; write pulse starts search
// - Bottom device reports system hit and multi-hit
// - Input sequence busy changes together everywhere
// - Hit-priority device drives output, else bottom
// - Hit summary driven by bottom device unless auto address is set
// - No hit: bottom clears address valid flag
// - Automatic address output drives on own hit
// - Select register: broadcast flag plus device number
// - Broadcast write target chosen by attribute
// - Broadcast read answered by one attribute device
// - Common registers written in every device
// - Search results update three or five registers
// - Broadcast reads: priority address, bottom summary
// - Per-device results readable with targeted access
// - Hit priority: uppermost hit, passed down chain
// - Empty priority: uppermost free entry, passed down
// - Bottom flag set only in last device
// - At most 32 devices share buses
`ifndef CCS_REGS_VH
`define CCS_REGS_VH
`define CCS_OFS_SELECT      12'h000
`define CCS_OFS_IDENT       12'h004
`define CCS_OFS_IP_CFG      12'h008
`define CCS_OFS_OP_CFG      12'h00C
`define CCS_OFS_HHA         12'h010
`define CCS_OFS_HIT_DATA    12'h014
`define CCS_OFS_HIT_SUMMARY_STATUS       12'h018
`define CCS_OFS_CMP         12'h01C
`define CCS_OFS_SEQ_HIT     12'h020
`define CCS_OFS_TABLE       12'h024
`define CCS_OFS_CTRL        12'h028
`define CCS_OFS_STATUS      12'h02C
`define CCS_SEL_NUM_MSB     4
`define CCS_SEL_ALL_BIT     5
`define CCS_IDENT_BOT_BIT   5
`define CCS_HHA_VALID_BIT   31
`define CCS_HST_HIT_BIT     0
`define CCS_HST_MULTI_BIT   1
`define CCS_CTRL_AUTO_BIT   0
`define CCS_CTRL_TC_BIT     1
`define CCS_OP_SEL_LSB      0
`define CCS_RST_SELECT      6'h20
`define CCS_RST_ZERO        32'h00000000
`define CCS_IP_BUSY_CYC     4'h4
`define CCS_OP_STEP_CYC     4'h2
`define CCS_MAX_DEVICES     6'h20
`endif

//--- sim/ccs_steer_properties.sv
/* Port checker for ccs_steer: busy lengths, chain and bus release.
   Bound to every ccs_steer; sees its ports only, one clock domain. */
`timescale 1ns/10ps
module ccs_steer_props (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic pwrite,
    input wire logic host_drive_en,
    input wire logic key_write_pulse,
    input wire logic local_hit,
    input wire logic local_empty,
    input wire logic hit_chain_in_n,
    input wire logic hit_chain_out_n,
    input wire logic empty_chain_out_n,
    input wire logic op_start,
    input wire logic result_drive_en,
    input wire logic ip_busy_n,
    input wire logic op_busy_n,
    input wire logic seq_hit_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rstn);
    a_ip_busy_four: assert property (
        key_write_pulse && ip_busy_n |=> !ip_busy_n [*4] ##1 ip_busy_n)
        else $error("input busy length wrong");
    a_op_busy_three: assert property (
        op_start && op_busy_n && ip_busy_n |=> !op_busy_n [*3] ##1 op_busy_n)
        else $error("output busy length wrong");
    a_own_hit_out: assert property (
        local_hit |-> !hit_chain_out_n)
        else $error("own hit not passed down");
    a_no_hit_out: assert property (
        !local_hit && hit_chain_in_n && $past(hit_chain_in_n, 1) && $past(hit_chain_in_n, 2)
        && $past(hit_chain_in_n, 3) && $past(hit_chain_in_n, 4) |-> hit_chain_out_n)
        else $error("hit chain low without any hit");
    a_own_free_out: assert property (
        local_empty |-> !empty_chain_out_n)
        else $error("free entry not passed down");
    a_result_release: assert property (
        result_drive_en |-> !op_busy_n || !ip_busy_n)
        else $error("result bus driven outside a sequence");
    a_host_release: assert property (
        host_drive_en |-> psel && !pwrite)
        else $error("host bus driven outside a read");
    a_seq_flag: assert property (
        seq_hit_n == !local_hit)
        else $error("sequence hit flag wrong");
endmodule
bind ccs_steer ccs_steer_props u_ccs_steer_props (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .pwrite(pwrite),
    .host_drive_en(host_drive_en), .key_write_pulse(key_write_pulse),
    .local_hit(local_hit), .local_empty(local_empty),
    .hit_chain_in_n(hit_chain_in_n), .hit_chain_out_n(hit_chain_out_n),
    .empty_chain_out_n(empty_chain_out_n), .op_start(op_start),
    .result_drive_en(result_drive_en), .ip_busy_n(ip_busy_n),
    .op_busy_n(op_busy_n), .seq_hit_n(seq_hit_n));

//--- sim/ccs_upper_model.sv
/* Upper neighbour model: drives the active-low chain inputs.
   Assumes the bench sets hit, multi-hit and free state of the upper part. */
`timescale 1ns/10ps
module ccs_upper_model (
    input  wire logic sys_clk,
    input  wire logic rstn,
    input  wire logic up_hit,
    input  wire logic up_multi,
    input  wire logic up_free,
    output logic      hit_n,
    output logic      multi_n,
    output logic      empty_n
);
    // Launched from a flop like a real neighbour; idle lines sit high
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            hit_n   <= 1'b1;
            multi_n <= 1'b1;
            empty_n <= 1'b1;
        end else begin
            hit_n   <= ~up_hit;
            multi_n <= ~up_multi;
            empty_n <= ~up_free;
        end
    end
endmodule

//--- sim/test_ccs_steer.sv
/* Self-checking bench for ccs_steer as the bottom device of a chain.
   Assumes zero-wait APB and the upper neighbour model on the chain. */
`timescale 1ns/10ps
module test_ccs_steer;
    logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, key_input_bus = 32'h0, local_hit_addr = 32'h0;
    logic        key_write_pulse = 0, local_hit = 0, local_empty = 0, op_start = 0;
    logic        up_hit = 0, up_free = 0, drv_q, hit_in_n, multi_in_n, empty_in_n;
    logic [31:0] prdata, rd_q, n, m, error_cnt = 0, checks = 0;
    logic        pready, host_drive_en, hit_chain_out_n, result_drive_en;
    logic        ip_busy_n, op_busy_n, empty_chain_out_n;
    logic        tw_pulse, tw_q, multi_out_n;
    logic [31:0] res_bus;

    always #50 sys_clk = ~sys_clk;

    ccs_upper_model u_ccs_upper_model (.sys_clk(sys_clk), .rstn(rstn), .up_hit(up_hit),
        .up_multi(1'b0), .up_free(up_free), .hit_n(hit_in_n), .multi_n(multi_in_n), .empty_n(empty_in_n));
    ccs_steer u_ccs_steer (.sys_clk(sys_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(), .host_drive_en(host_drive_en), .key_input_bus(key_input_bus),
        .key_write_pulse(key_write_pulse), .local_hit(local_hit), .local_multi_hit(1'b0),
        .local_empty(local_empty), .local_hit_addr(local_hit_addr), .local_hit_entry(32'h0000005A),
        .local_empty_entry(32'h000000A5), .hit_chain_in_n(hit_in_n), .multi_hit_chain_in_n(multi_in_n),
        .empty_chain_in_n(empty_in_n), .hit_chain_out_n(hit_chain_out_n), .multi_hit_chain_out_n(multi_out_n),
        .empty_chain_out_n(empty_chain_out_n), .op_start(op_start), .result_output_bus(res_bus),
        .result_drive_en(result_drive_en), .ip_busy_n(ip_busy_n), .op_busy_n(op_busy_n),
        .seq_hit_n(), .table_write_pulse(tw_pulse));

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 32'h1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 32'h1;
            $display("wrong value at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // One APB transfer; read data taken at the pready edge only
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        @(posedge sys_clk);
        while (pready !== 1'b1) @(posedge sys_clk);
        rd_q = prdata;
        drv_q = host_drive_en;
        tw_q = tw_pulse;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task t_config;
        apb(1'b0, 12'h000, 32'h0);
        chk(rd_q, 32'h00000020);
        apb(1'b1, 12'h004, 32'h00000020);
        apb(1'b1, 12'h008, 32'h000000A5);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd_q[30:0], drv_q}, 32'h0000014B);
        apb(1'b0, 12'hFFC, 32'h0);
        chk(rd_q, 32'h00000000);
    endtask
    // Targeted at another device: common register still stored
    task t_target;
        apb(1'b1, 12'h000, 32'h00000005);
        apb(1'b1, 12'h008, 32'h0000003C);
        apb(1'b0, 12'h008, 32'h0);
        chk(32'(drv_q), 32'h0);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b0, 12'h008, 32'h0);
        chk({rd_q[30:0], drv_q}, 32'h00000079);
        apb(1'b1, 12'h000, 32'h00000020);
    endtask
    // Layout mode lets a broadcast reach the table; else targeted only
    task t_table;
        apb(1'b1, 12'h028, 32'h00000002);
        apb(1'b1, 12'h024, 32'h00000011);
        chk(32'(tw_q), 32'h1);
        apb(1'b1, 12'h028, 32'h00000000);
        apb(1'b1, 12'h024, 32'h00000011);
        chk(32'(tw_q), 32'h0);
        apb(1'b1, 12'h000, 32'h00000000);
        apb(1'b1, 12'h024, 32'h00000011);
        chk(32'(tw_q), 32'h1);
        apb(1'b1, 12'h000, 32'h00000020);
    endtask
    task t_search;
        key_input_bus <= 32'h1234ABCD;
        key_write_pulse <= 1'b1;
        @(posedge sys_clk);
        key_write_pulse <= 1'b0;
        n = 32'h0;
        repeat (8) begin
            @(posedge sys_clk);
            if (ip_busy_n === 1'b0) n = n + 32'h1;
        end
        chk(n, 32'h4);
    endtask
    task t_output;
        apb(1'b1, 12'h00C, 32'h00000002);
        op_start <= 1'b1;
        @(posedge sys_clk);
        op_start <= 1'b0;
        n = 32'h0;
        m = 32'h0;
        repeat (8) begin
            @(posedge sys_clk);
            if (op_busy_n === 1'b0) n = n + 32'h1;
            if (result_drive_en === 1'b1) m = m + 32'h1;
        end
        chk(n, 32'h3);
        chk(m, 32'h2);
        chk(res_bus, 32'h00000000);
    endtask
    // Read address then summary; bottom answers summary regardless
    task rd_pair(input logic [31:0] exp_a, input logic [31:0] exp_s);
        repeat (8) @(posedge sys_clk);
        apb(1'b0, 12'h010, 32'h0);
        chk({rd_q[31], 30'h0, drv_q}, exp_a);
        apb(1'b0, 12'h018, 32'h0);
        chk({rd_q[0], 30'h0, drv_q}, exp_s);
    endtask
    task t_priority;
        t_search();
        rd_pair(32'h00000001, 32'h00000001);
        local_hit <= 1'b1;
        local_hit_addr <= 32'h00000123;
        @(posedge sys_clk);
        chk(32'(hit_chain_out_n), 32'h0);
        t_search();
        rd_pair(32'h80000001, 32'h80000001);
        chk(res_bus, 32'h80000123);
        up_hit <= 1'b1;
        t_search();
        rd_pair(32'h80000000, 32'h80000001);
        chk(32'(multi_out_n), 32'h0);
        local_empty <= 1'b1;
        @(posedge sys_clk);
        chk(32'(empty_chain_out_n), 32'h0);
    endtask
    task finish_test;
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 32'h0 && checks != 32'h0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Watchdog well beyond the under two hundred cycles the tests need
    initial begin
        #2000000;
        error_cnt = error_cnt + 32'h1;
        finish_test();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        t_config();
        t_target();
        t_table();
        t_output();
        t_priority();
        finish_test();
    end
endmodule
